// ===== core/evfs_top.sv
// Event input decoder: set point selection and function dispatch.
// Assumes contacts on eventIn are asynchronous; all other inputs are on clock.
`timescale 1ns/100ps
`default_nettype none
`include "evfs_regs.svh"

// Behaviour
// [RL1] Count one: input 1 picks set point 0/1
// [RL2] Count two: inputs 1,2 form set point index
// [RL3] With inputs, key select needs count zero, enable
// [RL4] Without inputs, key select needs enable only
// [RL5] Key selector value is the set point index
// [RL6] Each input holds one function assignment code
// [RL7] Reject function already held by another input
// [RL8] Level change counts after 50 ms stable
// [RL9] Program start accepted, inert without program pattern
// [RL10] Partial tune accepted, inert under heating/cooling
// [RL11] Run/stop input on stops control
// [RL12] Stop indicator lit while control stopped
// [RL13] Auto/manual input on selects manual, indicator lit
// [RL14] Program input on starts, off resets and stops
// [RL15] Inversion input on flips configured direction
// [RL16] Full tune runs while on, cancels on off
// [RL17] Partial tune runs while on, cancels on off
// [RL18] Setting lock input on blocks parameter changes
// [RL19] Communications may also select the set point
// [RL20] Alarm latch cancel clears latches on turn-on
// [RL21] Count zero: all inputs run their functions
// [RL22] Set point count resets to one
// [RL23] Synchronise and count stable ticks per input
module evfs_top #(
    parameter int FILTER_CYCLES = `EVFS_FILTER_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [`EVFS_NUM_INPUTS-1:0] eventIn,
    input wire logic hasEventInputs,
    input wire logic spCountWrite,
    input wire logic [1:0] spCountIn,
    input wire logic keySpEnable,
    input wire logic [`EVFS_SP_W-1:0] keySpIndex,
    input wire logic commSpWrite,
    input wire logic [`EVFS_SP_W-1:0] commSpIndex,
    input wire logic assignWrite,
    input wire logic [1:0] assignIndex,
    input wire evfs_pkg::evfs_func_t assignCode,
    input wire logic programPatternOn,
    input wire logic heatCoolMode,
    input wire logic directionConfig,
    output logic assignRejected,
    output logic [1:0] multipleSetpointSelect,
    output logic [`EVFS_SP_W-1:0] activeSp,
    output evfs_pkg::evfs_src_t activeSpSource,
    output logic controlStop,
    output logic stopIndicator,
    output logic manualMode,
    output logic manualIndicator,
    output logic programStart,
    output logic programReset,
    output logic programEndClear,
    output logic effectiveDirect,
    output logic fullTuneExec,
    output logic fullTuneCancel,
    output logic partialTuneExec,
    output logic partialTuneCancel,
    output logic settingLock,
    output logic alarmLatchClear
);

    logic [`EVFS_NUM_INPUTS-1:0] filtered;
    evfs_pkg::evfs_func_t codes [`EVFS_NUM_INPUTS];
    logic [`EVFS_NUM_INPUTS-1:0] funcEnable;
    logic [`EVFS_SP_W-1:0] commSp_reg;
    logic [`EVFS_SP_W-1:0] spNext;
    evfs_pkg::evfs_src_t srcNext;
    logic runStopLvl;
    logic manualLvl;
    logic programLvl;
    logic invertLvl;
    logic fullTuneLvl;
    logic partialTuneLvl;
    logic lockLvl;
    logic latchLvl;
    logic programPrev_reg;
    logic fullTunePrev_reg;
    logic partialTunePrev_reg;
    logic latchPrev_reg;
    logic forcedStop_reg;
    logic forcedStopNext;
    logic stopNext;

    genvar g;
    generate
        for (g = 0; g < `EVFS_NUM_INPUTS; g++)
        begin : gen_filter
            evfs_input_filter #(
                .FILTER_CYCLES(FILTER_CYCLES)
            ) u_filter (
                .clock(clock),
                .rst(rst),
                .contactIn(eventIn[g]),
                .level(filtered[g])
            );
        end
    endgenerate

    evfs_assign_table u_table (
        .clock(clock),
        .rst(rst),
        .assignWrite(assignWrite),
        .assignIndex(assignIndex),
        .assignCode(assignCode),
        .codes(codes),
        .assignRejected(assignRejected)
    );

    // Set point count parameter
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            multipleSetpointSelect <= `EVFS_SPCOUNT_RESET; // [RL22]
        end
        else if (spCountWrite)
        begin
            multipleSetpointSelect <= spCountIn;
        end
    end

    // Inputs not taken by set point selection run their functions
    always_comb
    begin
        funcEnable = '0;
        if (hasEventInputs)
        begin
            unique case (multipleSetpointSelect)
                2'h1: funcEnable = 4'hE;
                2'h2: funcEnable = 4'hC;
                default: funcEnable = 4'hF; // [RL21]
            endcase
        end
    end

    // Level of each function from the input that carries its code
    always_comb
    begin
        runStopLvl = 1'b0;
        manualLvl = 1'b0;
        programLvl = 1'b0;
        invertLvl = 1'b0;
        fullTuneLvl = 1'b0;
        partialTuneLvl = 1'b0;
        lockLvl = 1'b0;
        latchLvl = 1'b0;
        for (int i = 0; i < `EVFS_NUM_INPUTS; i++)
        begin
            if (funcEnable[i] && filtered[i])
            begin
                unique case (codes[i])
                    evfs_pkg::EVFS_FUNC_RUN_STOP: runStopLvl = 1'b1;
                    evfs_pkg::EVFS_FUNC_AUTO_MANUAL: manualLvl = 1'b1;
                    evfs_pkg::EVFS_FUNC_PROGRAM_START: programLvl = programPatternOn; // [RL9]
                    evfs_pkg::EVFS_FUNC_DIRECTION_INVERT: invertLvl = 1'b1;
                    evfs_pkg::EVFS_FUNC_FULL_TUNE: fullTuneLvl = 1'b1;
                    evfs_pkg::EVFS_FUNC_PARTIAL_TUNE: partialTuneLvl = !heatCoolMode; // [RL10]
                    evfs_pkg::EVFS_FUNC_SETTING_LOCK: lockLvl = 1'b1;
                    evfs_pkg::EVFS_FUNC_ALARM_LATCH_CANCEL: latchLvl = 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // Set point source: event inputs, then keys, then communications
    always_comb
    begin
        spNext = commSp_reg; // [RL19]
        srcNext = evfs_pkg::EVFS_SRC_COMM;
        if (hasEventInputs && multipleSetpointSelect == 2'h1)
        begin
            spNext = {1'b0, filtered[0]}; // [RL1]
            srcNext = evfs_pkg::EVFS_SRC_EVENT;
        end
        else if (hasEventInputs && multipleSetpointSelect == 2'h2)
        begin
            spNext = {filtered[1], filtered[0]}; // [RL2]
            srcNext = evfs_pkg::EVFS_SRC_EVENT;
        end
        else if (keySpEnable && (!hasEventInputs || multipleSetpointSelect == 2'h0)) // [RL3] [RL4]
        begin
            spNext = keySpIndex; // [RL5]
            srcNext = evfs_pkg::EVFS_SRC_KEY;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            commSp_reg <= `EVFS_SP_RESET;
            activeSp <= `EVFS_SP_RESET;
            activeSpSource <= evfs_pkg::EVFS_SRC_COMM;
        end
        else
        begin
            if (commSpWrite)
            begin
                commSp_reg <= commSpIndex; // [RL19]
            end
            activeSp <= spNext;
            activeSpSource <= srcNext;
        end
    end

    // Program reset forces stop until the program is started again
    always_comb
    begin
        forcedStopNext = forcedStop_reg;
        if (programPrev_reg && !programLvl)
        begin
            forcedStopNext = 1'b1; // [RL14]
        end
        else if (programLvl && !programPrev_reg)
        begin
            forcedStopNext = 1'b0;
        end
        stopNext = runStopLvl || forcedStopNext; // [RL11]
    end

    // Run/stop and auto/manual state with their indicators
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            forcedStop_reg <= 1'b0;
            controlStop <= 1'b0;
            stopIndicator <= 1'b0;
            manualMode <= 1'b0;
            manualIndicator <= 1'b0;
        end
        else
        begin
            forcedStop_reg <= forcedStopNext;
            controlStop <= stopNext; // [RL11]
            stopIndicator <= stopNext; // [RL12]
            manualMode <= manualLvl; // [RL13]
            manualIndicator <= manualLvl; // [RL13]
        end
    end

    // Edge-triggered commands for program, tuning and alarm latches
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            programPrev_reg <= 1'b0;
            fullTunePrev_reg <= 1'b0;
            partialTunePrev_reg <= 1'b0;
            latchPrev_reg <= 1'b0;
            programStart <= 1'b0;
            programReset <= 1'b0;
            programEndClear <= 1'b0;
            fullTuneCancel <= 1'b0;
            partialTuneCancel <= 1'b0;
            alarmLatchClear <= 1'b0;
        end
        else
        begin
            programPrev_reg <= programLvl;
            fullTunePrev_reg <= fullTuneLvl;
            partialTunePrev_reg <= partialTuneLvl;
            latchPrev_reg <= latchLvl;
            programStart <= programLvl && !programPrev_reg; // [RL14]
            programReset <= programPrev_reg && !programLvl; // [RL14]
            programEndClear <= programPrev_reg && !programLvl; // [RL14]
            fullTuneCancel <= fullTunePrev_reg && !fullTuneLvl; // [RL16]
            partialTuneCancel <= partialTunePrev_reg && !partialTuneLvl; // [RL17]
            alarmLatchClear <= latchLvl && !latchPrev_reg; // [RL20]
        end
    end

    // Level-following controls
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            effectiveDirect <= 1'b0;
            fullTuneExec <= 1'b0;
            partialTuneExec <= 1'b0;
            settingLock <= 1'b0;
        end
        else
        begin
            effectiveDirect <= directionConfig ^ invertLvl; // [RL15]
            fullTuneExec <= fullTuneLvl; // [RL16]
            partialTuneExec <= partialTuneLvl; // [RL17]
            settingLock <= lockLvl; // [RL18]
        end
    end

    AST_SP_ONE: assert property (@(posedge clock) disable iff (rst) // [RL1]
        hasEventInputs && multipleSetpointSelect == 2'h1
            |=> activeSp == {1'b0, $past(filtered[0])})
        else $error("set point does not follow event input 1");
    AST_SP_TWO: assert property (@(posedge clock) disable iff (rst) // [RL2]
        hasEventInputs && multipleSetpointSelect == 2'h2
            |=> activeSp == $past(filtered[1:0]))
        else $error("set point does not follow event inputs 1 and 2");
    AST_KEY_SEL: assert property (@(posedge clock) disable iff (rst) // [RL3]
        keySpEnable && hasEventInputs && multipleSetpointSelect == 2'h0
            |=> activeSp == $past(keySpIndex) && activeSpSource == evfs_pkg::EVFS_SRC_KEY)
        else $error("key set point not applied");
    AST_KEY_NO_EVENTS: assert property (@(posedge clock) disable iff (rst) // [RL4]
        keySpEnable && !hasEventInputs |=> activeSp == $past(keySpIndex))
        else $error("key set point not applied without event inputs");
    AST_STOP_IND: assert property (@(posedge clock) disable iff (rst) // [RL12]
        controlStop == stopIndicator)
        else $error("stop indicator differs from stop state");
    AST_RUN_STOP: assert property (@(posedge clock) disable iff (rst) // [RL11]
        runStopLvl |=> controlStop)
        else $error("control not stopped by run/stop input");
    AST_PROG_RESET: assert property (@(posedge clock) disable iff (rst) // [RL14]
        programPrev_reg && !programLvl |=> programReset && programEndClear && controlStop)
        else $error("program reset did not stop control");
    AST_DIRECTION: assert property (@(posedge clock) disable iff (rst) // [RL15]
        ##1 effectiveDirect == ($past(directionConfig) ^ $past(invertLvl)))
        else $error("effective direction wrong");

    AST_PARTIAL_HC: assert property (@(posedge clock) disable iff (rst) // [RL10]
        heatCoolMode |=> !partialTuneExec)
        else $error("partial tune active under heating/cooling");

    AST_ALARM_CLR: assert property (@(posedge clock) disable iff (rst) // [RL20]
        latchLvl && !latchPrev_reg |=> alarmLatchClear ##1 !alarmLatchClear)
        else $error("alarm latch clear pulse missing");

endmodule
`default_nettype wire

// ===== core/evfs_regs.svh
// Constants for the event input function select block: codes, reset values, timing.
// Assumes a single 20 MHz controller clock.
`ifndef EVFS_REGS_SVH
`define EVFS_REGS_SVH

// Clock rate and contact filter time
`define EVFS_CLOCK_KHZ 20000
`define EVFS_FILTER_MS 50
`define EVFS_FILTER_CYCLES (`EVFS_FILTER_MS * `EVFS_CLOCK_KHZ)
`define EVFS_FILTER_CNT_W 20

// Number of event inputs and field widths
`define EVFS_NUM_INPUTS 4
`define EVFS_CODE_W 4
`define EVFS_SP_W 2

// Reset values
`define EVFS_SPCOUNT_RESET 2'h1
`define EVFS_SP_RESET 2'h0
`define EVFS_CODE_RESET 4'h0

`endif

// ===== core/evfs_pkg.sv
// Types shared by the event input function select block.
// Assumes evfs_regs.svh is on the include path.
`include "evfs_regs.svh"

package evfs_pkg;

    // Function code carried by each event input assignment
    typedef enum logic [`EVFS_CODE_W-1:0] {
        EVFS_FUNC_NONE = 4'h0,
        EVFS_FUNC_RUN_STOP = 4'h1,
        EVFS_FUNC_AUTO_MANUAL = 4'h2,
        EVFS_FUNC_PROGRAM_START = 4'h3,
        EVFS_FUNC_DIRECTION_INVERT = 4'h4,
        EVFS_FUNC_FULL_TUNE = 4'h5,
        EVFS_FUNC_PARTIAL_TUNE = 4'h6,
        EVFS_FUNC_SETTING_LOCK = 4'h7,
        EVFS_FUNC_ALARM_LATCH_CANCEL = 4'h8
    } evfs_func_t;

    // Source of the active set point
    typedef enum logic [3:0] {
        EVFS_SRC_EVENT = 4'h1,
        EVFS_SRC_KEY = 4'h2,
        EVFS_SRC_COMM = 4'h4
    } evfs_src_t;

endpackage

// ===== core/evfs_input_filter.sv
// One event input: two-flop synchroniser and minimum-duration filter.
// Assumes the contact is asynchronous to clock.
`timescale 1ns/100ps
`default_nettype none
`include "evfs_regs.svh"

module evfs_input_filter #(
    parameter int FILTER_CYCLES = `EVFS_FILTER_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic contactIn,
    output logic level
);

    localparam logic [`EVFS_FILTER_CNT_W-1:0] LAST_COUNT =
        `EVFS_FILTER_CNT_W'(FILTER_CYCLES - 1);

    logic syncA_reg;
    logic syncB_reg;
    logic [`EVFS_FILTER_CNT_W-1:0] count_reg;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            syncA_reg <= 1'b0;
            syncB_reg <= 1'b0;
        end
        else
        begin
            syncA_reg <= contactIn;
            syncB_reg <= syncA_reg;
        end
    end

    // A new level is taken only after it has held for the full filter time
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            count_reg <= '0;
            level <= 1'b0;
        end
        else if (syncB_reg == level)
        begin
            count_reg <= '0;
        end
        else if (count_reg == LAST_COUNT) // [RL8] [RL23]
        begin
            count_reg <= '0;
            level <= syncB_reg;
        end
        else
        begin
            count_reg <= count_reg + 1'b1;
        end
    end

    AST_FILTER_MIN: assert property (@(posedge clock) disable iff (rst) // [RL8]
        level != $past(level) |-> $past(count_reg) == LAST_COUNT)
        else $error("event level changed before filter time");

endmodule
`default_nettype wire

// ===== core/evfs_assign_table.sv
// Event input assignment codes with rejection of duplicated functions.
// Assumes writes come from the operator setting logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "evfs_regs.svh"

module evfs_assign_table (
    input wire logic clock,
    input wire logic rst,
    input wire logic assignWrite,
    input wire logic [1:0] assignIndex,
    input wire evfs_pkg::evfs_func_t assignCode,
    output evfs_pkg::evfs_func_t codes [`EVFS_NUM_INPUTS],
    output logic assignRejected
);

    logic duplicate;

    always_comb
    begin
        duplicate = 1'b0;
        for (int i = 0; i < `EVFS_NUM_INPUTS; i++)
        begin
            if (i != int'(assignIndex) && codes[i] == assignCode
                && assignCode != evfs_pkg::EVFS_FUNC_NONE)
            begin
                duplicate = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < `EVFS_NUM_INPUTS; i++)
            begin
                codes[i] <= evfs_pkg::evfs_func_t'(`EVFS_CODE_RESET);
            end
            assignRejected <= 1'b0;
        end
        else
        begin
            assignRejected <= assignWrite && duplicate; // [RL7]
            if (assignWrite && !duplicate) // [RL6] [RL9] [RL10]
            begin
                codes[assignIndex] <= assignCode;
            end
        end
    end

    AST_DUP_REJECT: assert property (@(posedge clock) disable iff (rst) // [RL7]
        assignWrite && duplicate |=> assignRejected && codes[$past(assignIndex)]
            == $past(codes[assignIndex]))
        else $error("duplicate function assignment was stored");

endmodule
`default_nettype wire

// ===== verif/evfs_contacts.sv
// Switch contact model for the event inputs, with a short bounce option.
// Assumes clock is the controller clock; contacts change between edges.
`timescale 1ns/100ps
`default_nettype none

module evfs_contacts (
    input wire logic clock,
    output var logic [3:0] eventIn
);
    initial eventIn = 4'h0;

    // Contacts are asynchronous, so they move well away from the edge
    task automatic set_level(input int idx, input logic val);
        @(posedge clock);
        #13;
        eventIn[idx] = val;
    endtask

    // Bounce: the contact flips for len cycles, then returns
    task automatic glitch(input int idx, input int len);
        @(posedge clock);
        #13;
        eventIn[idx] = ~eventIn[idx];
        repeat (len) @(posedge clock);
        #13;
        eventIn[idx] = ~eventIn[idx];
    endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the event input decoder.
// Assumes evfs_pkg and the core files are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb;
    localparam int FILT = 4;
    logic clock, rst, hasEvt, spcW, keyEn, commW, asgW, patOn, hcMode, dirCfg;
    logic [1:0] spcIn, keyIdx, commIdx, asgIdx;
    evfs_pkg::evfs_func_t asgCode;
    logic [3:0] eventIn;
    logic asgRej, stopC, stopI, manM, manI, pStart, pReset, pEnd, effDir;
    logic fExec, fCan, pExec, pCan, lock, alClr;
    logic [1:0] spCount, activeSp;
    evfs_pkg::evfs_src_t spSrc;
    logic [7:0] lvl, seen;
    int errors = 0;
    int n_compared = 0;
    logic [47:0] tbl [11] = '{
        48'h1_0_1_0_C0_00_00_00, 48'h2_0_1_0_30_00_00_00,
        48'h4_0_1_0_08_00_00_00, 48'h4_0_1_1_00_00_08_00,
        48'h5_0_1_0_04_00_00_04, 48'h6_0_1_0_02_00_00_02,
        48'h7_0_1_0_01_00_00_00, 48'h8_0_1_0_00_01_00_00,
        48'h6_1_1_0_00_00_00_00, 48'h3_0_0_0_00_00_00_00,
        48'h3_0_1_0_00_20_C0_18};

    evfs_contacts u_sw (.clock(clock), .eventIn(eventIn));

    evfs_top #(.FILTER_CYCLES(FILT)) u_dut (
        .clock(clock), .rst(rst), .eventIn(eventIn), .hasEventInputs(hasEvt),
        .spCountWrite(spcW), .spCountIn(spcIn), .keySpEnable(keyEn),
        .keySpIndex(keyIdx), .commSpWrite(commW), .commSpIndex(commIdx),
        .assignWrite(asgW), .assignIndex(asgIdx), .assignCode(asgCode),
        .programPatternOn(patOn), .heatCoolMode(hcMode), .directionConfig(dirCfg),
        .assignRejected(asgRej), .multipleSetpointSelect(spCount), .activeSp(activeSp),
        .activeSpSource(spSrc), .controlStop(stopC), .stopIndicator(stopI),
        .manualMode(manM), .manualIndicator(manI), .programStart(pStart),
        .programReset(pReset), .programEndClear(pEnd), .effectiveDirect(effDir),
        .fullTuneExec(fExec), .fullTuneCancel(fCan), .partialTuneExec(pExec),
        .partialTuneCancel(pCan), .settingLock(lock), .alarmLatchClear(alClr)
    );

    assign lvl = {stopC, stopI, manM, manI, effDir, fExec, pExec, lock};

    // One-cycle pulses are collected so that none is missed between checks
    always @(posedge clock)
        seen <= seen | {1'b0, asgRej, pStart, pReset, pEnd, fCan, pCan, alClr};

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic end_of_test();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic contact(input int idx, input logic val);
        u_sw.set_level(idx, val);
        settle(FILT + 6);
    endtask

    task automatic spc(input logic [1:0] v);
        @(posedge clock);
        spcW <= 1'b1;
        spcIn <= v;
        @(posedge clock);
        spcW <= 1'b0;
        settle(3);
    endtask

    task automatic asg(input logic [1:0] idx, input logic [3:0] code, input logic rej);
        @(posedge clock);
        asgW <= 1'b1;
        asgIdx <= idx;
        asgCode <= evfs_pkg::evfs_func_t'(code);
        // Cleared off the edge so a collector update cannot undo it
        #1;
        seen = 8'h00;
        @(posedge clock);
        asgW <= 1'b0;
        settle(3);
        chk({7'h00, seen[6]}, {7'h00, rej});
    endtask

    task automatic t_reset();
        settle(19);
        chk({6'h00, spCount}, 8'h01);
        chk({6'h00, activeSp}, 8'h00);
        chk(lvl, 8'h00);
        @(posedge clock);
        rst <= 1'b0;
        settle(3);
    endtask

    task automatic t_setpoint();
        int i;
        for (i = 0; i < 2; i++)
        begin
            contact(0, i[0]);
            chk({6'h00, activeSp}, i[7:0]);
            chk({4'h0, spSrc}, {4'h0, evfs_pkg::EVFS_SRC_EVENT});
        end
        contact(0, 1'b0);
        contact(1, 1'b1);
        chk({6'h00, activeSp}, 8'h00);
        spc(2'h2);
        for (i = 0; i < 4; i++)
        begin
            contact(0, i[0]);
            contact(1, i[1]);
            chk({6'h00, activeSp}, i[7:0]);
        end
        contact(0, 1'b0);
        contact(1, 1'b0);
    endtask

    task automatic t_key_comm();
        int i;
        @(posedge clock);
        keyEn <= 1'b1;
        keyIdx <= 2'h3;
        spc(2'h1);
        chk({4'h0, spSrc}, {4'h0, evfs_pkg::EVFS_SRC_EVENT});
        spc(2'h0);
        for (i = 0; i < 4; i++)
        begin
            @(posedge clock);
            keyIdx <= i[1:0];
            settle(3);
            chk({6'h00, activeSp}, i[7:0]);
            chk({4'h0, spSrc}, {4'h0, evfs_pkg::EVFS_SRC_KEY});
        end
        @(posedge clock);
        hasEvt <= 1'b0;
        keyIdx <= 2'h2;
        spc(2'h1);
        chk({2'h0, spSrc, activeSp}, {2'h0, evfs_pkg::EVFS_SRC_KEY, 2'h2});
        @(posedge clock);
        keyEn <= 1'b0;
        commW <= 1'b1;
        commIdx <= 2'h3;
        @(posedge clock);
        commW <= 1'b0;
        settle(3);
        chk({2'h0, spSrc, activeSp}, {2'h0, evfs_pkg::EVFS_SRC_COMM, 2'h3});
        @(posedge clock);
        hasEvt <= 1'b1;
    endtask

    task automatic t_assign();
        asg(2'h0, 4'h1, 1'b0);
        asg(2'h1, 4'h1, 1'b1);
        asg(2'h0, 4'h1, 1'b0);
        asg(2'h1, 4'h2, 1'b0);
        asg(2'h3, 4'h2, 1'b1);
        asg(2'h1, 4'h0, 1'b0);
        asg(2'h2, 4'h0, 1'b0);
    endtask

    task automatic t_filter();
        spc(2'h0);
        u_sw.glitch(0, FILT - 2);
        settle(FILT + 6);
        chk({7'h00, stopC}, 8'h00);
        u_sw.set_level(0, 1'b1);
        settle(FILT);
        chk({7'h00, stopC}, 8'h00);
        settle(6);
        chk({7'h00, stopC}, 8'h01);
        contact(0, 1'b0);
        spc(2'h1);
        contact(0, 1'b1);
        chk({6'h00, stopC, activeSp[0]}, 8'h01);
        contact(0, 1'b0);
        asg(2'h0, 4'h0, 1'b0);
        spc(2'h0);
    endtask

    task automatic t_functions();
        int i;
        logic [47:0] e;
        for (i = 0; i < 11; i++)
        begin
            e = tbl[i];
            @(posedge clock);
            hcMode <= e[40];
            patOn <= e[36];
            dirCfg <= e[32];
            asg(2'h2, e[47:44], 1'b0);
            seen = 8'h00;
            contact(2, 1'b1);
            chk(lvl, e[31:24]);
            chk(seen, e[23:16]);
            seen = 8'h00;
            contact(2, 1'b0);
            chk(lvl, e[15:8]);
            chk(seen, e[7:0]);
        end
    endtask

    initial
    begin
        #(50 * 30000);
        errors++;
        end_of_test();
    end

    initial
    begin
        rst = 1'b1;
        hasEvt = 1'b1;
        patOn = 1'b1;
        {spcW, keyEn, commW, asgW, hcMode, dirCfg} = 6'h00;
        {spcIn, keyIdx, commIdx, asgIdx} = 8'h00;
        asgCode = evfs_pkg::EVFS_FUNC_NONE;
        seen = 8'h00;
        t_reset();
        t_setpoint();
        t_key_comm();
        t_assign();
        t_filter();
        t_functions();
        end_of_test();
    end
endmodule
`default_nettype wire
